//--- hdl/rtc_pkg.sv
// constants for the reload timer control block
package rtc_pkg;
   localparam int unsigned  BYTE_W        = 8;
   localparam int unsigned  BIT_IDX_W     = 3;
   // register addresses on the special function register bus
   localparam logic [7:0]   ADDR_CTRL     = 8'hC8;
   localparam logic [7:0]   ADDR_RLD_LO   = 8'hCA;
   localparam logic [7:0]   ADDR_RLD_HI   = 8'hCB;
   localparam logic [7:0]   ADDR_CNT_LO   = 8'hCC;
   localparam logic [7:0]   ADDR_CNT_HI   = 8'hCD;
   // control register field positions
   localparam int unsigned  BIT_HIGH_OVF  = 7;
   localparam int unsigned  BIT_LOW_OVF   = 6;
   localparam int unsigned  BIT_LOW_IRQEN = 5;
   localparam int unsigned  BIT_CAPTURE   = 4;
   localparam int unsigned  BIT_SPLIT     = 3;
   localparam int unsigned  BIT_RUN       = 2;
   localparam int unsigned  BIT_UNUSED    = 1;
   localparam int unsigned  BIT_EXTCLK    = 0;
   // bits that software may store; the unused bit stays zero
   localparam logic [7:0]   CTRL_WR_MASK  = 8'hFD;
   localparam logic [7:0]   CTRL_RESET    = 8'h00;
   localparam logic [7:0]   BYTE_RESET    = 8'h00;
   localparam logic [7:0]   BYTE_ONES     = 8'hFF;
   localparam logic [7:0]   BYTE_ONE      = 8'h01;
   localparam logic [7:0]   RDATA_NONE    = 8'h00;
   // prescalers
   localparam int unsigned  CORE_DIV      = 12;
   localparam int unsigned  EXT_DIV       = 8;
   localparam int unsigned  CORE_DIV_W    = 4;
   localparam int unsigned  EXT_DIV_W     = 3;
   localparam logic [3:0]   CORE_DIV_LAST = 4'(CORE_DIV - 1);
   localparam logic [2:0]   EXT_DIV_LAST  = 3'(EXT_DIV - 1);
   localparam logic [3:0]   CORE_DIV_ZERO = 4'h0;
   localparam logic [2:0]   EXT_DIV_ZERO  = 3'h0;
   localparam logic [3:0]   CORE_DIV_INC  = 4'h1;
   localparam logic [2:0]   EXT_DIV_INC   = 3'h1;
endpackage

//--- hdl/rtc_byte_counter.sv
// one 8-bit counter byte with software write, reload and wrap detect
`timescale 1ns/1ps
module rtc_byte_counter
   import rtc_pkg::*;
(
   input  wire logic                      mclk_i,
   input  wire logic                      rst_i,
   input  wire logic                      count_en_i,
   input  wire logic                      reload_i,
   input  wire logic [rtc_pkg::BYTE_W-1:0] reload_val_i,
   input  wire logic                      wr_i,
   input  wire logic [rtc_pkg::BYTE_W-1:0] wdata_i,
   output logic      [rtc_pkg::BYTE_W-1:0] count_o,
   output logic                           wrap_o
);
   import rtc_pkg::*;

   logic [BYTE_W-1:0] next_count;

   // wrap is the step from all ones to zero on an enabled count
   assign wrap_o = count_en_i & (count_o == BYTE_ONES);

   // software write beats reload, reload beats the increment
   assign next_count = wr_i       ? wdata_i :
                       reload_i   ? reload_val_i :
                       count_en_i ? count_o + BYTE_ONE :
                                    count_o;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         count_o <= BYTE_RESET;
      end else begin
         count_o <= next_count;
      end
   end
endmodule

//--- hdl/rtc_reload_timer_control.sv
// auto-reload timer: control register, prescalers, counters and capture
`timescale 1ns/1ps
module rtc_reload_timer_control
   import rtc_pkg::*;
(
   input  wire logic                         mclk_i,
   input  wire logic                         rst_i,
   input  wire logic [7:0]                   sfr_addr_i,
   input  wire logic                         sfr_wr_i,
   input  wire logic [rtc_pkg::BYTE_W-1:0]    sfr_wdata_i,
   input  wire logic                         sfr_rd_i,
   input  wire logic                         sfr_bit_wr_i,
   input  wire logic [rtc_pkg::BIT_IDX_W-1:0] sfr_bit_idx_i,
   input  wire logic                         sfr_bit_val_i,
   input  wire logic                         high_byte_fast_clock_select_i,
   input  wire logic                         low_byte_fast_clock_select_i,
   input  wire logic                         timer_irq_enable_i,
   input  wire logic                         ext_osc_i,
   output logic      [rtc_pkg::BYTE_W-1:0]    sfr_rdata_o,
   output logic                              timer_irq_req_o,
   output logic      [rtc_pkg::BYTE_W-1:0]    timer_control_register_o,
   output logic      [rtc_pkg::BYTE_W-1:0]    counter_low_byte_o,
   output logic      [rtc_pkg::BYTE_W-1:0]    counter_high_byte_o,
   output logic      [rtc_pkg::BYTE_W-1:0]    reload_low_byte_o,
   output logic      [rtc_pkg::BYTE_W-1:0]    reload_high_byte_o
);
   import rtc_pkg::*;

   // control register and reload pair state
   logic                  high_overflow_flag;
   logic                  low_overflow_flag;
   logic                  low_byte_irq_enable;
   logic                  capture_mode_enable;
   logic                  split_mode_select;
   logic                  run_control;
   logic                  external_clock_select;
   logic [BYTE_W-1:0]     reload_low_byte;
   logic [BYTE_W-1:0]     reload_high_byte;

   // prescaler and external clock state
   logic [CORE_DIV_W-1:0] core_div_cnt;
   logic [EXT_DIV_W-1:0]  ext_div_cnt;
   logic                  ext_sync1;
   logic                  ext_sync2;
   logic                  ext_prev;

   // bus decode
   logic                  sel_ctrl;
   logic                  sel_rld_lo;
   logic                  sel_rld_hi;
   logic                  sel_cnt_lo;
   logic                  sel_cnt_hi;
   logic                  ctrl_write;
   logic [BYTE_W-1:0]     ctrl_now;
   logic [BYTE_W-1:0]     ctrl_bitmerge;
   logic [BYTE_W-1:0]     ctrl_wdata;
   logic [BYTE_W-1:0]     rd_mux;

   // timing and counting nets
   logic                  core_div_tick;
   logic                  ext_rise;
   logic                  ext_div_tick;
   logic                  slow_tick;
   logic                  low_tick;
   logic                  high_tick;
   logic                  low_en;
   logic                  high_en;
   logic                  low_wrap;
   logic                  high_wrap;
   logic                  low_reload;
   logic                  high_reload;
   logic                  capture_evt;
   logic                  set_high;
   logic                  set_low;
   logic [BYTE_W-1:0]     count_lo;
   logic [BYTE_W-1:0]     count_hi;

   logic                  next_high_flag;
   logic                  next_low_flag;
   logic                  next_irq;
   logic [BYTE_W-1:0]     next_rld_lo;
   logic [BYTE_W-1:0]     next_rld_hi;

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   // register decode
   assign sel_ctrl   = addr_hit(sfr_addr_i, ADDR_CTRL);
   assign sel_rld_lo = addr_hit(sfr_addr_i, ADDR_RLD_LO);
   assign sel_rld_hi = addr_hit(sfr_addr_i, ADDR_RLD_HI);
   assign sel_cnt_lo = addr_hit(sfr_addr_i, ADDR_CNT_LO);
   assign sel_cnt_hi = addr_hit(sfr_addr_i, ADDR_CNT_HI);

   // control register as software sees it; the unused bit is never stored
   always_comb begin
      ctrl_now                = CTRL_RESET;
      ctrl_now[BIT_HIGH_OVF]  = high_overflow_flag;
      ctrl_now[BIT_LOW_OVF]   = low_overflow_flag;
      ctrl_now[BIT_LOW_IRQEN] = low_byte_irq_enable;
      ctrl_now[BIT_CAPTURE]   = capture_mode_enable;
      ctrl_now[BIT_SPLIT]     = split_mode_select;
      ctrl_now[BIT_RUN]       = run_control;
      ctrl_now[BIT_EXTCLK]    = external_clock_select;
   end

   // bit-addressed write replaces a single bit of the present value
   always_comb begin
      ctrl_bitmerge = ctrl_now;
      ctrl_bitmerge[sfr_bit_idx_i] = sfr_bit_val_i;
   end

   assign ctrl_write = sel_ctrl & (sfr_wr_i | sfr_bit_wr_i);
   assign ctrl_wdata = (sfr_bit_wr_i ? ctrl_bitmerge : sfr_wdata_i) & CTRL_WR_MASK;

   assign rd_mux = sel_ctrl   ? ctrl_now :
                   sel_rld_lo ? reload_low_byte :
                   sel_rld_hi ? reload_high_byte :
                   sel_cnt_lo ? count_lo :
                   sel_cnt_hi ? count_hi :
                                RDATA_NONE;

   // core clock divided by 12
   assign core_div_tick = (core_div_cnt == CORE_DIV_LAST);

   // external oscillator divided by 8; the tick marks the divided clock's falling edge
   assign ext_rise     = ext_sync2 & ~ext_prev;
   assign ext_div_tick = ext_rise & (ext_div_cnt == EXT_DIV_LAST);

   // one external select serves both bytes, fast select overrides per byte
   assign slow_tick = external_clock_select ? ext_div_tick : core_div_tick;
   assign low_tick  = low_byte_fast_clock_select_i  | slow_tick;
   assign high_tick = high_byte_fast_clock_select_i | slow_tick;

   // mode steering of the two byte counters
   // in 16-bit mode the high byte steps only on the low byte's wrap
   assign low_en  = split_mode_select ? low_tick : (low_tick & run_control);
   assign high_en = split_mode_select ? (high_tick & run_control) : low_wrap;

   // unsplit: both bytes reload on the full wrap; split: each on its own wrap
   assign low_reload  = split_mode_select ? low_wrap : high_wrap;
   assign high_reload = high_wrap;

   assign capture_evt = capture_mode_enable & ext_div_tick;

   assign set_high = high_wrap | capture_evt;
   assign set_low  = low_wrap;

   // a set arriving with a software clear wins
   assign next_high_flag = set_high |
                           (ctrl_write ? ctrl_wdata[BIT_HIGH_OVF] : high_overflow_flag);
   assign next_low_flag  = set_low |
                           (ctrl_write ? ctrl_wdata[BIT_LOW_OVF] : low_overflow_flag);

   // interrupt level follows the flags as they will stand
   assign next_irq = timer_irq_enable_i &
                     (next_high_flag | (low_byte_irq_enable & next_low_flag));

   // capture loads the reload pair; it overrides a same-cycle software write
   assign next_rld_lo = capture_evt ? count_lo :
                        (sfr_wr_i & sel_rld_lo) ? sfr_wdata_i : reload_low_byte;
   assign next_rld_hi = capture_evt ? count_hi :
                        (sfr_wr_i & sel_rld_hi) ? sfr_wdata_i : reload_high_byte;

   rtc_byte_counter u_low (
      .mclk_i       (mclk_i),
      .rst_i        (rst_i),
      .count_en_i   (low_en),
      .reload_i     (low_reload),
      .reload_val_i (reload_low_byte),
      .wr_i         (sfr_wr_i & sel_cnt_lo),
      .wdata_i      (sfr_wdata_i),
      .count_o      (count_lo),
      .wrap_o       (low_wrap)
   );

   rtc_byte_counter u_high (
      .mclk_i       (mclk_i),
      .rst_i        (rst_i),
      .count_en_i   (high_en),
      .reload_i     (high_reload),
      .reload_val_i (reload_high_byte),
      .wr_i         (sfr_wr_i & sel_cnt_hi),
      .wdata_i      (sfr_wdata_i),
      .count_o      (count_hi),
      .wrap_o       (high_wrap)
   );

   // external oscillator synchroniser and edge history
   // the pin is asynchronous: only the second flop feeds the edge detector
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev  <= 1'b0;
      end else begin
         ext_sync1 <= ext_osc_i;
         ext_sync2 <= ext_sync1;
         ext_prev  <= ext_sync2;
      end
   end

   // prescaler counters
   // the core prescaler runs free, so run never shifts the tick phase
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         core_div_cnt <= CORE_DIV_ZERO;
         ext_div_cnt  <= EXT_DIV_ZERO;
      end else begin
         core_div_cnt <= core_div_tick ? CORE_DIV_ZERO : core_div_cnt + CORE_DIV_INC;
         if (ext_rise) begin
            ext_div_cnt <= ext_div_cnt + EXT_DIV_INC;
         end
      end
   end

   // control bits
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         low_byte_irq_enable   <= 1'b0;
         capture_mode_enable   <= 1'b0;
         split_mode_select     <= 1'b0;
         run_control           <= 1'b0;
         external_clock_select <= 1'b0;
      end else if (ctrl_write) begin
         low_byte_irq_enable   <= ctrl_wdata[BIT_LOW_IRQEN];
         capture_mode_enable   <= ctrl_wdata[BIT_CAPTURE];
         split_mode_select     <= ctrl_wdata[BIT_SPLIT];
         run_control           <= ctrl_wdata[BIT_RUN];
         external_clock_select <= ctrl_wdata[BIT_EXTCLK];
      end
   end

   // overflow flags; only software ever clears them
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         high_overflow_flag <= 1'b0;
         low_overflow_flag  <= 1'b0;
      end else begin
         high_overflow_flag <= next_high_flag;
         low_overflow_flag  <= next_low_flag;
      end
   end

   // reload pair, written by software or loaded by a capture
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         reload_low_byte  <= BYTE_RESET;
         reload_high_byte <= BYTE_RESET;
      end else begin
         reload_low_byte  <= next_rld_lo;
         reload_high_byte <= next_rld_hi;
      end
   end

   // interrupt request level
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         timer_irq_req_o <= 1'b0;
      end else begin
         timer_irq_req_o <= next_irq;
      end
   end

   // read data register, loaded only by a read strobe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= RDATA_NONE;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= rd_mux;
      end
   end

   // registered mirrors of the internal state
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         timer_control_register_o <= CTRL_RESET;
         counter_low_byte_o       <= BYTE_RESET;
         counter_high_byte_o      <= BYTE_RESET;
         reload_low_byte_o        <= BYTE_RESET;
         reload_high_byte_o       <= BYTE_RESET;
      end else begin
         timer_control_register_o <= ctrl_now;
         counter_low_byte_o       <= count_lo;
         counter_high_byte_o      <= count_hi;
         reload_low_byte_o        <= reload_low_byte;
         reload_high_byte_o       <= reload_high_byte;
      end
   end
endmodule

//--- dv/rtc_reload_timer_control_chk.sv
// concurrent assertions on the reload timer control ports
`timescale 1ns/1ps
module rtc_reload_timer_control_chk (
   input  wire logic                       mclk_i,
   input  wire logic                       rst_i,
   input  wire logic [7:0]                 sfr_addr_i,
   input  wire logic                       sfr_wr_i,
   input  wire logic                       sfr_rd_i,
   input  wire logic                       sfr_bit_wr_i,
   input  wire logic                       low_byte_fast_clock_select_i,
   input  wire logic                       timer_irq_enable_i,
   input  wire logic [rtc_pkg::BYTE_W-1:0] sfr_rdata_o,
   input  wire logic                       timer_irq_req_o,
   input  wire logic [rtc_pkg::BYTE_W-1:0] timer_control_register_o,
   input  wire logic [rtc_pkg::BYTE_W-1:0] counter_low_byte_o,
   input  wire logic [rtc_pkg::BYTE_W-1:0] counter_high_byte_o
);
   import rtc_pkg::*;
   wire logic [7:0] m      = timer_control_register_o;
   wire logic       ctl_wr = (sfr_wr_i || sfr_bit_wr_i) && sfr_addr_i == ADDR_CTRL;
   wire logic       lo_wr  = sfr_wr_i && sfr_addr_i == ADDR_CNT_LO;
   wire logic       hi_wr  = sfr_wr_i && sfr_addr_i == ADDR_CNT_HI;
   wire logic       mapped = sfr_addr_i == ADDR_CTRL || sfr_addr_i inside {[8'hCA:8'hCD]};
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   AST_UNUSED_ZERO: assert property (m[BIT_UNUSED] == 1'b0)
      else $error("unused control bit reads one");
   AST_HIGH_SW_CLEAR: assert property ($fell(m[BIT_HIGH_OVF]) |-> $past(ctl_wr, 2))
      else $error("high flag cleared without a software write");
   AST_LOW_SW_CLEAR: assert property ($fell(m[BIT_LOW_OVF]) |-> $past(ctl_wr, 2))
      else $error("low flag cleared without a software write");
   AST_IRQ_HIGH: assert property (m[7] && $past(timer_irq_enable_i, 2) |-> $past(timer_irq_req_o))
      else $error("high flag set but no interrupt request");
   AST_IRQ_LOW: assert property (m[6] && m[5] && $past(m[5])
      && $past(timer_irq_enable_i, 2) |-> $past(timer_irq_req_o))
      else $error("low flag enabled but no interrupt request");
   AST_IRQ_CAUSE: assert property ((!m[7] && !m[6]) || !$past(timer_irq_enable_i, 2)
      |-> !$past(timer_irq_req_o))
      else $error("interrupt request without a cause");
   AST_RD_CTRL: assert property (sfr_rd_i && sfr_addr_i == ADDR_CTRL |=> sfr_rdata_o == m)
      else $error("control read data wrong");
   AST_RD_UNMAPPED: assert property (sfr_rd_i && !mapped |=> sfr_rdata_o == RDATA_NONE)
      else $error("unmapped read not zero");
   AST_SPLIT_HIGH_STOP: assert property ($past(m[3]) && !$past(m[2]) && !$past(hi_wr, 2)
      |-> $stable(counter_high_byte_o))
      else $error("split high byte counts while stopped");
   AST_UNSPLIT_STOP: assert property (!$past(m[3]) && !$past(m[2]) && !$past(lo_wr, 2)
      && !$past(hi_wr, 2) |-> $stable({counter_high_byte_o, counter_low_byte_o}))
      else $error("16-bit counter moves while stopped");
   AST_SPLIT_LOW_RUNS: assert property ($past(m[3])
      && $past(low_byte_fast_clock_select_i, 2) && !$past(lo_wr, 2)
      && $past(counter_low_byte_o) != BYTE_ONES
      |-> counter_low_byte_o != $past(counter_low_byte_o))
      else $error("split low byte not counting");
   COV_SPLIT_HIGH: cover property (m[7] && m[3]);
   COV_LOW_FLAG: cover property (m[6] && !m[3]);
   COV_IRQ: cover property ($rose(timer_irq_req_o));
endmodule
bind rtc_reload_timer_control rtc_reload_timer_control_chk i_chk (.mclk_i, .rst_i, .sfr_addr_i,
   .sfr_wr_i, .sfr_rd_i, .sfr_bit_wr_i, .low_byte_fast_clock_select_i, .timer_irq_enable_i,
   .sfr_rdata_o, .timer_irq_req_o, .timer_control_register_o, .counter_low_byte_o,
   .counter_high_byte_o);

//--- dv/rtc_reload_timer_control_tb.sv
// self-checking bench for the reload timer control block
`timescale 1ns/1ps
module rtc_reload_timer_control_tb;
   import rtc_pkg::*;
   logic        mclk_i, rst_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i;
   logic        hf, lf, ie, osc_en, irq;
   logic        osc = 1'b0;
   logic [7:0]  sfr_addr_i, sfr_wdata_i, rdata, tcr, clo, chi, rlo, rhi, a, b;
   logic [2:0]  sfr_bit_idx_i;
   logic [15:0] r;
   logic [7:0]  adr [6] = '{ADDR_CTRL, ADDR_RLD_LO, ADDR_RLD_HI, ADDR_CNT_LO, ADDR_CNT_HI, 8'hC9};
   int          n_mismatch, total_checks, rm[int];
   rtc_reload_timer_control i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
      .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_idx_i(sfr_bit_idx_i), .sfr_bit_val_i(sfr_bit_val_i),
      .high_byte_fast_clock_select_i(hf), .low_byte_fast_clock_select_i(lf),
      .timer_irq_enable_i(ie), .ext_osc_i(osc), .sfr_rdata_o(rdata), .timer_irq_req_o(irq),
      .timer_control_register_o(tcr), .counter_low_byte_o(clo), .counter_high_byte_o(chi),
      .reload_low_byte_o(rlo), .reload_high_byte_o(rhi));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) if (osc_en) osc <= ~osc;
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // byte write, or bit write of control with index d[2:0] and value d[3]
   task automatic sw(input logic bm, input logic [7:0] ad, input logic [7:0] d);
      @(posedge mclk_i);
      sfr_wr_i <= !bm;
      sfr_bit_wr_i <= bm;
      sfr_addr_i <= ad;
      sfr_wdata_i <= d;
      sfr_bit_idx_i <= d[2:0];
      sfr_bit_val_i <= d[3];
      @(posedge mclk_i);
      sfr_wr_i <= 1'b0;
      sfr_bit_wr_i <= 1'b0;
      if (!bm) rm[ad] = d;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge mclk_i);
      sfr_rd_i <= 1'b1;
      sfr_addr_i <= ad;
      @(posedge mclk_i);
      sfr_rd_i <= 1'b0;
      @(negedge mclk_i);
      chk(rdata, e);
   endtask
   task automatic wf(input int bt);
      int i;
      for (i = 0; i < 400 && tcr[bt] !== 1'b1; i++) @(negedge mclk_i);
      if (i == 400) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   // counts gained by each byte over n cycles; eh below zero skips the high byte
   task automatic dl(input int n, input logic [7:0] el, input int eh);
      repeat (2) @(negedge mclk_i);
      a = clo;
      b = chi;
      repeat (n) @(negedge mclk_i);
      chk(8'(clo - a), el);
      if (eh >= 0) chk(8'(chi - b), 8'(eh));
   endtask
   initial begin
      {sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i, hf, lf, ie, osc_en} = '0;
      sfr_addr_i = 8'h00;
      sfr_wdata_i = 8'h00;
      sfr_bit_idx_i = 3'h0;
      rst_i = 1'b1;
      n_mismatch = 0;
      total_checks = 0;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      void'($urandom(33));
      foreach (adr[i]) rd(adr[i], 8'h00);
      sw(0, 8'hC9, 8'hAA);
      rd(8'hC9, 8'h00);
      r = 16'($urandom) & 16'hFF7F;
      sw(0, ADDR_RLD_LO, r[7:0]);
      sw(0, ADDR_RLD_HI, r[15:8]);
      rd(ADDR_RLD_LO, 8'(rm[ADDR_RLD_LO]));
      rd(ADDR_RLD_HI, 8'(rm[ADDR_RLD_HI]));
      sw(0, ADDR_CTRL, 8'h02);
      rd(ADDR_CTRL, 8'h00);
      sw(1, ADDR_CTRL, 8'h09);
      rd(ADDR_CTRL, 8'h00);
      sw(0, ADDR_CNT_LO, 8'hF0);
      sw(0, ADDR_CNT_HI, 8'hFF);
      lf <= 1'b1;
      ie <= 1'b1;
      sw(0, ADDR_CTRL, 8'h04);
      wf(7);
      chk({chi, clo}, r);
      chk(tcr, 8'hC4);
      chk(irq, 1'b1);
      sw(1, ADDR_CTRL, 8'h02);
      repeat (40) @(negedge mclk_i);
      chk(tcr[7:6], 2'b11);
      sw(1, ADDR_CTRL, 8'h07);
      sw(1, ADDR_CTRL, 8'h06);
      repeat (2) @(negedge mclk_i);
      chk({irq, tcr}, 9'h000);
      // high reload kept below 0x80 so the split high byte cannot wrap again soon
      r = 16'($urandom) & 16'h7F7F;
      sw(0, ADDR_RLD_LO, r[7:0]);
      sw(0, ADDR_RLD_HI, r[15:8]);
      sw(0, ADDR_CNT_HI, 8'h55);
      sw(0, ADDR_CNT_LO, 8'hF0);
      sw(0, ADDR_CTRL, 8'h08);
      wf(6);
      chk({chi, clo}, {8'h55, r[7:0]});
      chk(irq, 1'b0);
      sw(1, ADDR_CTRL, 8'h0D);
      repeat (2) @(negedge mclk_i);
      chk(irq, 1'b1);
      sw(0, ADDR_CNT_HI, 8'hF8);
      hf <= 1'b1;
      sw(1, ADDR_CTRL, 8'h0A);
      wf(7);
      chk(chi, r[15:8]);
      sw(0, ADDR_CTRL, 8'h04);
      hf <= 1'b0;
      lf <= 1'b0;
      sw(0, ADDR_CNT_LO, 8'h00);
      sw(0, ADDR_CNT_HI, 8'h00);
      dl(120, 8'd10, 0);
      sw(0, ADDR_CTRL, 8'h0D);
      osc_en <= 1'b1;
      // let the synchroniser and the divide-by-8 reach their steady period first
      repeat (20) @(negedge mclk_i);
      dl(160, 8'h0A, 10);
      chk(tcr[7], 1'b0);
      @(posedge mclk_i);
      lf <= 1'b1;
      dl(16, 8'd16, -1);
      sw(0, ADDR_CNT_LO, 8'h00);
      sw(0, ADDR_CNT_HI, 8'h00);
      sw(0, ADDR_CTRL, 8'h14);
      wf(7);
      chk({rhi, rlo} + 16'h0001, {chi, clo});
      stop_test();
   end
endmodule
